// ===== hdl/mfi_pkg.sv
// constants of the multi-function interrupt controller
// assumes one system clock and a synchronous active-high reset
`default_nettype none
package mfi_pkg;
    // sizes
    localparam int SRC_N = 17;
    localparam int GRP_N = 6;
    localparam int TMR_N = 4;
    localparam int CONV_W = 12;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int EVT_N = 3;

    // source flag positions
    localparam int SRC_CONV_DONE = 0;
    localparam int SRC_LIMIT = 1;
    localparam int SRC_CAP_OVF = 2;
    localparam int SRC_CAP_CMP = 3;
    localparam int SRC_PERIOD = 4;
    localparam int SRC_DUTY0 = 5;
    localparam int SRC_TWOWIRE = 8;
    localparam int SRC_TMR0 = 9;

    // sources that belong to each group (group 1 at index 0)
    localparam logic [SRC_N-1:0] GRP1_MASK = 17'h0000f;
    localparam logic [SRC_N-1:0] GRP2_MASK = 17'h000f0;
    localparam logic [SRC_N-1:0] GRP3_MASK = 17'h00600;
    localparam logic [SRC_N-1:0] GRP4_MASK = 17'h01800;
    localparam logic [SRC_N-1:0] GRP5_MASK = 17'h06000;
    localparam logic [SRC_N-1:0] GRP6_MASK = 17'h18100;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_GRP_EN = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_GRP_FLAG = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SRC_EN = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_SRC_FLAG = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_BOUNDS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_VEC_STAT = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h20;

    // field positions
    localparam int CTRL_GIE_BIT = 0;
    localparam int CTRL_HI_BIT = 1;
    localparam int CTRL_LO_BIT = 2;
    localparam int BOUND_LO_LSB = 0;
    localparam int BOUND_UP_LSB = 16;
    localparam int VEC_LAST_LSB = 0;
    localparam int VEC_PEND_LSB = 8;
    localparam int EVT_VEC_BIT = 0;
    localparam int EVT_WAKE_BIT = 1;
    localparam int EVT_STALL_BIT = 2;

    // reset values
    localparam logic [SRC_N-1:0] SRC_RST = 17'h00000;
    localparam logic [GRP_N-1:0] GRP_RST = 6'h00;
    localparam logic [CONV_W-1:0] UPPER_RST = 12'hfff;
    localparam logic [CONV_W-1:0] LOWER_RST = 12'h000;
    localparam logic [EVT_N-1:0] EVT_RST = 3'h0;
endpackage
`default_nettype wire

// ===== hdl/multi_function_interrupt_ctrl.sv
// multi-function interrupt controller: source flags, groups, vectoring
// assumes a core that pushes only the pc on vector_call_out and that
// reports its return instructions and stack state as plain inputs
//
// What this block does
// [R1] converter sets done flag and limit flag
// [R2] limit flag from bounds with high/low enables
// [R3] vector needs global, group and source enables
// [R4] vector only when return stack not full
// [R5] converter service clears group flag, global enable
// [R6] capture overflow/compare flags, never cleared by service
// [R7] pwm period plus three duty sources, group two
// [R8] pwm service clears group two flag, global
// [R9] two-wire flag set on four conditions
// [R10] timer modules give A and P sources
// [R11] timer service clears only group flag, global
// [R12] any flag rise wakes, ignoring enables
// [R13] software pre-sets flags to block wake
// [R14] set flags stay until service or software
// [R15] vector entry pushes only the program counter
// [R16] interrupt return sets global, plain return not
// [R17] group flag set by any member source
// [R18] lowest pending group vectors first
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`default_nettype none
module multi_function_interrupt_ctrl (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic [mfi_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [mfi_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [mfi_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic conv_done_in,
    input wire logic [mfi_pkg::CONV_W-1:0] conv_result_in,
    input wire logic cap_ovf_in,
    input wire logic cap_cmp_in,
    input wire logic period_match_in,
    input wire logic [2:0] duty_match_in,
    input wire logic twowire_rx_in,
    input wire logic twowire_tx_in,
    input wire logic twowire_addr_in,
    input wire logic twowire_timeout_in,
    input wire logic [mfi_pkg::TMR_N-1:0] tmr_cmp_a_in,
    input wire logic [mfi_pkg::TMR_N-1:0] tmr_cmp_p_in,
    input wire logic stack_full_in,
    input wire logic sleep_in,
    input wire logic return_from_interrupt_in,
    input wire logic plain_return_in,
    output logic vector_call_out,
    output logic [2:0] vector_group_out,
    output logic pop_pc_out,
    output logic wake_out,
    output logic irq_out
);
    localparam int SN = mfi_pkg::SRC_N;
    localparam int GN = mfi_pkg::GRP_N;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [SN-1:0] group_mask(input int g);
        case (g)
            0: group_mask = mfi_pkg::GRP1_MASK;
            1: group_mask = mfi_pkg::GRP2_MASK;
            2: group_mask = mfi_pkg::GRP3_MASK;
            3: group_mask = mfi_pkg::GRP4_MASK;
            4: group_mask = mfi_pkg::GRP5_MASK;
            default: group_mask = mfi_pkg::GRP6_MASK;
        endcase
    endfunction

    function automatic logic [2:0] lowest_group(input logic [GN-1:0] r);
        lowest_group = 3'h0;
        for (int i = GN - 1; i >= 0; i--) begin
            if (r[i]) begin
                lowest_group = 3'(i);
            end
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic global_irq_enable;
    logic high_limit_enable;
    logic low_limit_enable;
    logic [GN-1:0] group_enable_n;
    logic [GN-1:0] group_flag_n;
    logic [SN-1:0] src_enable;
    logic [SN-1:0] src_flag;
    logic [mfi_pkg::CONV_W-1:0] upper_bound;
    logic [mfi_pkg::CONV_W-1:0] lower_bound;
    logic [2:0] last_group;
    logic [mfi_pkg::EVT_N-1:0] evt_status;
    logic [mfi_pkg::EVT_N-1:0] evt_mask;

    // ------------------------------------------------------------
    // register write decode
    // ------------------------------------------------------------
    wire wr_ctrl = reg_wr_in && reg_addr_in == mfi_pkg::OFS_CTRL;
    wire wr_grp_en = reg_wr_in && reg_addr_in == mfi_pkg::OFS_GRP_EN;
    wire wr_grp_flag = reg_wr_in && reg_addr_in == mfi_pkg::OFS_GRP_FLAG;
    wire wr_src_en = reg_wr_in && reg_addr_in == mfi_pkg::OFS_SRC_EN;
    wire wr_src_flag = reg_wr_in && reg_addr_in == mfi_pkg::OFS_SRC_FLAG;
    wire wr_bounds = reg_wr_in && reg_addr_in == mfi_pkg::OFS_BOUNDS;
    wire wr_evt_stat = reg_wr_in && reg_addr_in == mfi_pkg::OFS_EVT_STAT;
    wire wr_evt_mask = reg_wr_in && reg_addr_in == mfi_pkg::OFS_EVT_MASK;

    // ------------------------------------------------------------
    // source set events
    // ------------------------------------------------------------
    wire over_upper = conv_result_in > upper_bound;
    wire under_lower = conv_result_in < lower_bound;
    wire limit_compare_irq = (high_limit_enable && over_upper) ||
                             (low_limit_enable && under_lower); // R2
    wire twowire_any = twowire_rx_in || twowire_tx_in ||
                       twowire_addr_in || twowire_timeout_in; // R9

    logic [SN-1:0] src_set;
    assign src_set[mfi_pkg::SRC_CONV_DONE] = conv_done_in; // R1
    assign src_set[mfi_pkg::SRC_LIMIT] =
        conv_done_in && limit_compare_irq; // R1
    assign src_set[mfi_pkg::SRC_CAP_OVF] = cap_ovf_in; // R6
    assign src_set[mfi_pkg::SRC_CAP_CMP] = cap_cmp_in; // R6
    assign src_set[mfi_pkg::SRC_PERIOD] = period_match_in; // R7
    assign src_set[mfi_pkg::SRC_DUTY0 +: 3] = duty_match_in; // R7
    assign src_set[mfi_pkg::SRC_TWOWIRE] = twowire_any; // R9

    genvar t;
    generate
        for (t = 0; t < mfi_pkg::TMR_N; t++) begin : g_tmr
            assign src_set[mfi_pkg::SRC_TMR0 + 2 * t] = tmr_cmp_a_in[t]; // R10
            assign src_set[mfi_pkg::SRC_TMR0 + 2 * t + 1] =
                tmr_cmp_p_in[t]; // R10
        end
    endgenerate

    // software writes the flag value; a hardware set in the same cycle
    // wins, and service never touches these flags
    wire [SN-1:0] src_base = wr_src_flag ? reg_wdata_in[SN-1:0] : src_flag;
    wire [SN-1:0] next_src_flag = src_base | src_set; // R14
    wire [SN-1:0] src_rise = next_src_flag & ~src_flag;

    // ------------------------------------------------------------
    // group request and selection
    // ------------------------------------------------------------
    logic [GN-1:0] grp_set;
    logic [GN-1:0] grp_req;
    wire [SN-1:0] src_active = src_flag & src_enable;

    genvar g;
    generate
        for (g = 0; g < GN; g++) begin : g_grp
            assign grp_set[g] = |(src_rise & group_mask(g)); // R17
            assign grp_req[g] = group_flag_n[g] && group_enable_n[g] &&
                                |(src_active & group_mask(g)); // R3
        end
    endgenerate

    wire any_req = |grp_req;
    wire [2:0] sel = lowest_group(grp_req); // R18
    wire take = global_irq_enable && any_req && !stack_full_in; // R3 R4
    wire stall = global_irq_enable && any_req && stack_full_in;
    wire [GN-1:0] svc_clear = take ? GN'(6'h01 << sel) : GN'(0);

    wire [GN-1:0] grp_base = wr_grp_flag ? reg_wdata_in[GN-1:0] : group_flag_n;
    wire [GN-1:0] next_group_flag =
        (grp_base & ~svc_clear) | grp_set; // R5 R8 R11

    // global enable: service clears, interrupt return sets
    logic next_gie;
    always_comb begin
        if (take) begin
            next_gie = 1'b0; // R5 R8 R11
        end else if (return_from_interrupt_in) begin
            next_gie = 1'b1; // R16
        end else if (plain_return_in) begin
            next_gie = global_irq_enable; // R16
        end else if (wr_ctrl) begin
            next_gie = reg_wdata_in[mfi_pkg::CTRL_GIE_BIT];
        end else begin
            next_gie = global_irq_enable;
        end
    end

    // ------------------------------------------------------------
    // event status and interrupt line
    // ------------------------------------------------------------
    wire wake_evt = sleep_in && (|src_rise); // R12
    logic [mfi_pkg::EVT_N-1:0] evt_set;
    assign evt_set[mfi_pkg::EVT_VEC_BIT] = take;
    assign evt_set[mfi_pkg::EVT_WAKE_BIT] = wake_evt;
    assign evt_set[mfi_pkg::EVT_STALL_BIT] = stall;
    wire [mfi_pkg::EVT_N-1:0] evt_clr =
        wr_evt_stat ? reg_wdata_in[mfi_pkg::EVT_N-1:0] : mfi_pkg::EVT_RST;
    wire [mfi_pkg::EVT_N-1:0] next_evt = (evt_status & ~evt_clr) | evt_set;

    assign irq_out = |(evt_status & evt_mask);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            global_irq_enable <= 1'b0;
            high_limit_enable <= 1'b0;
            low_limit_enable <= 1'b0;
            group_enable_n <= mfi_pkg::GRP_RST;
            group_flag_n <= mfi_pkg::GRP_RST;
            src_enable <= mfi_pkg::SRC_RST;
            src_flag <= mfi_pkg::SRC_RST;
            upper_bound <= mfi_pkg::UPPER_RST;
            lower_bound <= mfi_pkg::LOWER_RST;
            evt_status <= mfi_pkg::EVT_RST;
            evt_mask <= mfi_pkg::EVT_RST;
        end else begin
            global_irq_enable <= next_gie;
            group_flag_n <= next_group_flag;
            src_flag <= next_src_flag;
            evt_status <= next_evt;
            if (wr_ctrl) begin
                high_limit_enable <= reg_wdata_in[mfi_pkg::CTRL_HI_BIT];
                low_limit_enable <= reg_wdata_in[mfi_pkg::CTRL_LO_BIT];
            end
            if (wr_grp_en) begin
                group_enable_n <= reg_wdata_in[GN-1:0];
            end
            if (wr_src_en) begin
                src_enable <= reg_wdata_in[SN-1:0];
            end
            if (wr_bounds) begin
                upper_bound <=
                    reg_wdata_in[mfi_pkg::BOUND_UP_LSB +: mfi_pkg::CONV_W];
                lower_bound <=
                    reg_wdata_in[mfi_pkg::BOUND_LO_LSB +: mfi_pkg::CONV_W];
            end
            if (wr_evt_mask) begin
                evt_mask <= reg_wdata_in[mfi_pkg::EVT_N-1:0];
            end
        end
    end

    // core side: vector call pushes only the pc, returns pop it
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            vector_call_out <= 1'b0;
            vector_group_out <= 3'h0;
            last_group <= 3'h0;
            pop_pc_out <= 1'b0;
            wake_out <= 1'b0;
        end else begin
            vector_call_out <= take; // R15
            pop_pc_out <= return_from_interrupt_in || plain_return_in; // R16
            wake_out <= wake_evt; // R12
            if (take) begin
                vector_group_out <= sel + 3'h1;
                last_group <= sel + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [mfi_pkg::DATA_W-1:0] rd_value;
    always_comb begin
        rd_value = '0;
        if (reg_addr_in == mfi_pkg::OFS_CTRL) begin
            rd_value[mfi_pkg::CTRL_GIE_BIT] = global_irq_enable;
            rd_value[mfi_pkg::CTRL_HI_BIT] = high_limit_enable;
            rd_value[mfi_pkg::CTRL_LO_BIT] = low_limit_enable;
        end else if (reg_addr_in == mfi_pkg::OFS_GRP_EN) begin
            rd_value[GN-1:0] = group_enable_n;
        end else if (reg_addr_in == mfi_pkg::OFS_GRP_FLAG) begin
            rd_value[GN-1:0] = group_flag_n;
        end else if (reg_addr_in == mfi_pkg::OFS_SRC_EN) begin
            rd_value[SN-1:0] = src_enable;
        end else if (reg_addr_in == mfi_pkg::OFS_SRC_FLAG) begin
            rd_value[SN-1:0] = src_flag;
        end else if (reg_addr_in == mfi_pkg::OFS_BOUNDS) begin
            rd_value[mfi_pkg::BOUND_UP_LSB +: mfi_pkg::CONV_W] = upper_bound;
            rd_value[mfi_pkg::BOUND_LO_LSB +: mfi_pkg::CONV_W] = lower_bound;
        end else if (reg_addr_in == mfi_pkg::OFS_VEC_STAT) begin
            rd_value[mfi_pkg::VEC_LAST_LSB +: 3] = last_group;
            rd_value[mfi_pkg::VEC_PEND_LSB +: GN] = grp_req;
        end else if (reg_addr_in == mfi_pkg::OFS_EVT_STAT) begin
            rd_value[mfi_pkg::EVT_N-1:0] = evt_status;
        end else if (reg_addr_in == mfi_pkg::OFS_EVT_MASK) begin
            rd_value[mfi_pkg::EVT_N-1:0] = evt_mask;
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_value : '0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    wire [GN-1:0] below_sel = GN'((6'h01 << sel) - 6'h01);

    property p_vec_enables;
        @(posedge clk_sys_in) disable iff (srst_in)
        take |-> global_irq_enable && group_enable_n[sel] &&
                 |(src_active & group_mask(int'(sel)));
    endproperty
    a_vec_enables: assert property (p_vec_enables) // R3
        else $error("vector taken without all enables");

    property p_vec_stack;
        @(posedge clk_sys_in) disable iff (srst_in)
        vector_call_out |-> !$past(stack_full_in);
    endproperty
    a_vec_stack: assert property (p_vec_stack) // R4
        else $error("vector taken with a full stack");

    property p_svc_clear;
        @(posedge clk_sys_in) disable iff (srst_in)
        take && !grp_set[sel] |=>
            !global_irq_enable && !group_flag_n[$past(sel)] &&
            vector_call_out && vector_group_out == $past(sel) + 3'h1;
    endproperty
    a_svc_clear: assert property (p_svc_clear) // R5 R8 R11 R15
        else $error("service did not clear group flag and global enable");

    property p_src_keep;
        @(posedge clk_sys_in) disable iff (srst_in)
        !wr_src_flag |=> (src_flag & $past(src_flag)) == $past(src_flag);
    endproperty
    a_src_keep: assert property (p_src_keep) // R6 R14
        else $error("source flag cleared without software");

    property p_limit;
        @(posedge clk_sys_in) disable iff (srst_in)
        conv_done_in && high_limit_enable && over_upper |=>
            src_flag[mfi_pkg::SRC_LIMIT] && src_flag[mfi_pkg::SRC_CONV_DONE];
    endproperty
    a_limit: assert property (p_limit) // R1 R2
        else $error("limit compare flag not set");

    property p_wake;
        @(posedge clk_sys_in) disable iff (srst_in)
        $past(sleep_in) && $rose(src_flag[mfi_pkg::SRC_TWOWIRE]) |-> wake_out;
    endproperty
    a_wake: assert property (p_wake) // R12
        else $error("flag rise did not wake");

    property p_return_from_interrupt;
        @(posedge clk_sys_in) disable iff (srst_in)
        return_from_interrupt_in && !take |=> global_irq_enable && pop_pc_out;
    endproperty
    a_return_from_interrupt: assert property (p_return_from_interrupt) // R16
        else $error("interrupt return did not set global enable");

    property p_ret;
        @(posedge clk_sys_in) disable iff (srst_in)
        plain_return_in && !global_irq_enable && !return_from_interrupt_in
            |=> !global_irq_enable && pop_pc_out;
    endproperty
    a_ret: assert property (p_ret) // R16
        else $error("plain return changed global enable");

    property p_group_set;
        @(posedge clk_sys_in) disable iff (srst_in)
        $rose(src_flag[mfi_pkg::SRC_PERIOD]) |-> group_flag_n[1];
    endproperty
    a_group_set: assert property (p_group_set) // R17 R7
        else $error("group flag not set by member source");

    property p_prio;
        @(posedge clk_sys_in) disable iff (srst_in)
        take |-> (grp_req & below_sel) == '0 && grp_req[sel];
    endproperty
    a_prio: assert property (p_prio) // R18
        else $error("higher priority group skipped");
endmodule
`default_nettype wire

// ===== tb/core_model.sv
// partner model of the processor core: return stack and return opcodes
// assumes the controller pulses vector_call_in once per vector entry
`default_nettype none
module core_model #(
    parameter int DEPTH = 1
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic vector_call_in,
    input wire logic pop_pc_in,
    input wire logic [1:0] ret_cmd_in,
    output logic stack_full_out,
    output logic return_from_interrupt_out,
    output logic plain_return_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int depth;
    assign stack_full_out = (depth >= DEPTH);
    // -----------------------------------------------------------------
    // stack: one entry per vector, the pc alone
    // -----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            depth <= 0;
            return_from_interrupt_out <= 1'b0;
            plain_return_out <= 1'b0;
        end else begin
            depth <= depth + int'(vector_call_in) - int'(pop_pc_in);
            return_from_interrupt_out <= ret_cmd_in[0] && depth > 0;
            plain_return_out <= ret_cmd_in[1] && depth > 0;
        end
    end
endmodule
`default_nettype wire

// ===== tb/test_multi_function_interrupt_ctrl.sv
// self-checking bench of the multi-function interrupt controller
// assumes core_model as the core and one 200 MHz system clock
`default_nettype none
module test_multi_function_interrupt_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CT = mfi_pkg::OFS_CTRL;
    localparam logic [7:0] GE = mfi_pkg::OFS_GRP_EN;
    localparam logic [7:0] GF = mfi_pkg::OFS_GRP_FLAG;
    localparam logic [7:0] SE = mfi_pkg::OFS_SRC_EN;
    localparam logic [7:0] SF = mfi_pkg::OFS_SRC_FLAG;
    localparam logic [7:0] ES = mfi_pkg::OFS_EVT_STAT;
    localparam logic [7:0] EM = mfi_pkg::OFS_EVT_MASK;
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [11:0] res = '0;
    logic [18:0] ev = '0;
    logic sleep = 1'b0;
    logic [1:0] ret_cmd = '0;
    logic [31:0] rdata;
    logic [2:0] grp;
    logic vec, pop, wake, irq, full, return_from_interrupt_l, ret_l, got;
    int error_cnt = 0;
    int samples_checked = 0;
    initial forever #2.5 clk_sys_in = ~clk_sys_in;
    multi_function_interrupt_ctrl dut (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
        .reg_rdata_out(rdata), .conv_done_in(ev[0]), .conv_result_in(res),
        .cap_ovf_in(ev[1]), .cap_cmp_in(ev[2]), .period_match_in(ev[3]),
        .duty_match_in(ev[6:4]), .twowire_rx_in(ev[7]),
        .twowire_tx_in(ev[8]), .twowire_addr_in(ev[9]),
        .twowire_timeout_in(ev[10]), .tmr_cmp_a_in(ev[14:11]),
        .tmr_cmp_p_in(ev[18:15]), .stack_full_in(full), .sleep_in(sleep),
        .return_from_interrupt_in(return_from_interrupt_l), .plain_return_in(ret_l),
        .vector_call_out(vec), .vector_group_out(grp), .pop_pc_out(pop),
        .wake_out(wake), .irq_out(irq));
    core_model #(.DEPTH(1)) core (
        .clk_in(clk_sys_in), .srst_in(srst_in), .vector_call_in(vec),
        .pop_pc_in(pop), .ret_cmd_in(ret_cmd), .stack_full_out(full),
        .return_from_interrupt_out(return_from_interrupt_l), .plain_return_out(ret_l));
    // -----------------------------------------------------------------
    // bus, pulse and compare helpers
    // -----------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_sys_in);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_sys_in);
        rd_s <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic pulse(input logic [18:0] v);
        @(posedge clk_sys_in);
        ev <= v;
        @(posedge clk_sys_in);
        ev <= '0;
    endtask
    // wake_out stands only in the cycle after the pulse
    task automatic pulse_wake(input logic [18:0] v, input logic e);
        pulse(v);
        #1 chk({31'h0, wake}, {31'h0, e});
    endtask
    // watch vec (0), pop (1) or wake (2) for n cycles
    task automatic win(input int sel, input int n);
        got = 1'b0;
        repeat (n) begin
            @(posedge clk_sys_in);
            #1 got = (sel == 2) ? wake : (sel == 1) ? pop : vec;
            if (got) break;
        end
    endtask
    task automatic vec_exp(input logic [2:0] g);
        win(0, 8);
        chk({31'h0, got}, 32'h1);
        chk({29'h0, grp}, {29'h0, g});
    endtask
    task automatic popx(input logic [1:0] k);
        @(posedge clk_sys_in);
        ret_cmd <= k;
        @(posedge clk_sys_in);
        ret_cmd <= 2'b00;
        win(1, 4);
        chk({31'h0, got}, 32'h1);
    endtask
    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_reset();
        rd(CT, 32'h0);
        rd(SF, 32'h0);
        rd(mfi_pkg::OFS_BOUNDS, 32'h0fff0000);
        @(posedge clk_sys_in);
        #1 chk(rdata, 32'h0);
        rd(8'h40, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test reset finished");
    endtask
    task automatic t_pwm();
        wr(SE, 32'hf0);
        wr(GE, 32'h2);
        pulse(19'h00070);
        rd(SF, 32'he0);
        rd(GF, 32'h2);
        wr(CT, 32'h1);
        vec_exp(3'd2);
        rd(CT, 32'h0);
        rd(GF, 32'h0);
        rd(SF, 32'he0);
        popx(2'b10);
        rd(CT, 32'h0);
        wr(CT, 32'h1);
        pulse(19'h00008);
        vec_exp(3'd2);
        popx(2'b10);
        $display("test pwm finished");
    endtask
    task automatic t_en();
        logic [2:0] tb[3] = '{3'b011, 3'b101, 3'b110};
        wr(SF, 32'h0);
        wr(GF, 32'h0);
        wr(CT, 32'h0);
        pulse(19'h00002);
        foreach (tb[i]) begin
            wr(CT, 32'h0);
            wr(GE, {31'h0, tb[i][1]});
            wr(SE, {29'h0, tb[i][0], 2'b00});
            wr(CT, {31'h0, tb[i][2]});
            win(0, 6);
            chk({31'h0, got}, 32'h0);
        end
        wr(SE, 32'h4);
        vec_exp(3'd1);
        pulse(19'h00004);
        rd(SF, 32'hc);
        $display("test enables finished");
    endtask
    task automatic t_stk();
        wr(SF, 32'h0);
        wr(ES, 32'h7);
        wr(EM, 32'h4);
        wr(CT, 32'h1);
        pulse(19'h00002);
        win(0, 8);
        chk({31'h0, got}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        rd(ES, 32'h4);
        wr(EM, 32'h0);
        @(posedge clk_sys_in);
        #1 chk({31'h0, irq}, 32'h0);
        wr(EM, 32'h4);
        popx(2'b10);
        vec_exp(3'd1);
        wr(ES, 32'h7);
        @(posedge clk_sys_in);
        #1 chk({31'h0, irq}, 32'h0);
        popx(2'b10);
        $display("test stack finished");
    endtask
    task automatic t_conv();
        logic [2:0] cc[4] = '{3'd2, 3'd2, 3'd4, 3'd4};
        logic [11:0] rr[4] = '{12'h900, 12'h050, 12'h050, 12'h900};
        logic [1:0] ee[4] = '{2'd3, 2'd1, 2'd3, 2'd1};
        wr(mfi_pkg::OFS_BOUNDS, 32'h08000100);
        foreach (cc[i]) begin
            wr(SF, 32'h0);
            wr(CT, {29'h0, cc[i]});
            res <= rr[i];
            pulse(19'h00001);
            rd(SF, {30'h0, ee[i]});
        end
        wr(SF, 32'h0);
        wr(GF, 32'h0);
        wr(SE, 32'h2);
        wr(CT, 32'h3);
        res <= 12'h900;
        pulse(19'h00001);
        vec_exp(3'd1);
        rd(CT, 32'h2);
        rd(GF, 32'h0);
        rd(SF, 32'h3);
        popx(2'b10);
        $display("test converter finished");
    endtask
    task automatic t_prio();
        wr(CT, 32'h0);
        wr(SF, 32'h0);
        wr(GF, 32'h0);
        wr(GE, 32'h3c);
        wr(SE, 32'h1ff00);
        pulse(19'h7ff80);
        rd(SF, 32'h1ff00);
        rd(GF, 32'h3c);
        wr(CT, 32'h1);
        for (int g = 3; g <= 6; g++) begin
            vec_exp(3'(g));
            if (g == 3) rd(GF, 32'h38);
            if (g == 3) rd(mfi_pkg::OFS_VEC_STAT, 32'h3803);
            popx(2'b01);
        end
        rd(CT, 32'h1);
        rd(SF, 32'h1ff00);
        wr(CT, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(SF, 32'h0);
            pulse(19'(19'h80 << i));
            rd(SF, 32'h100);
        end
        $display("test priority finished");
    endtask
    task automatic t_wake();
        wr(GE, 32'h0);
        wr(SE, 32'h0);
        wr(ES, 32'h7);
        wr(SF, 32'h20);
        sleep <= 1'b1;
        pulse_wake(19'h00010, 1'b0);
        pulse_wake(19'h00088, 1'b1);
        rd(ES, 32'h2);
        sleep <= 1'b0;
        $display("test wake finished");
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        t_reset();
        t_pwm();
        t_en();
        t_stk();
        t_conv();
        t_prio();
        t_wake();
        close_out();
    end
    initial begin
        repeat (10000) @(posedge clk_sys_in);
        error_cnt++;
        close_out();
    end
endmodule
`default_nettype wire
